// ==== core/digital_watchdog_timer.sv ====
// Digital watchdog: reloadable 7-bit downcounter behind one register,
// chip reset request with stabilisation hold, STOP/WAIT arbitration.
// Assumes all inputs but rst_b synchronous to sys_clk; option straps steady.
`timescale 1ns/1ns
`default_nettype none
`include "wdg_defines.svh"

module digital_watchdog_timer (
  input  wire logic              sys_clk,       // Internal clock, 25 MHz
  input  wire logic              rst_b,         // Async reset, active low
  input  wire wdg_pkg::regbus_req_s busReq,     // Register port request
  input  wire wdg_pkg::pwr_ctl_s pwrCtl,        // STOP, wake, NMI level
  input  wire logic              optHwAct,      // Strap: hardware activation
  input  wire logic              optExtStop,    // Strap: external stop control
  output logic [7:0]             regRdData,     // Read data, cycle after read
  output logic                   chipResetReq,  // Chip reset request
  output logic                   wdgActive,     // Watchdog armed
  output logic                   stopMode,      // CPU in stop, osc halted
  output logic                   waitMode       // CPU in wait
);
  import wdg_pkg::*;

  // ==========================================================
  // State
  typedef struct packed {
    pwr_e        pwr;
    logic [6:0]  cnt;
    logic        active;
    logic [3:0]  div;
    logic [7:0]  pre;
    logic        rstHold;
    logic [10:0] rstCnt;
    logic        optHw;
    logic        optExt;
    logic        optValid;
    logic [7:0]  rdData;
  } wdg_state_s;

  wdg_state_s q;
  wdg_state_s d;

  function automatic logic [5:0] rev6(input logic [5:0] v);
    logic [5:0] r;
    r = 6'h00;
    for (int i = 0; i < 6; i++) begin
      r[i] = v[5-i];
    end
    return r;
  endfunction

  // ==========================================================
  // Next state
  logic run;
  logic tick;
  logic step;
  logic hit;
  logic wrHit;
  logic fire;
  logic actNew;

  always_comb begin
    d      = q;
    hit    = (busReq.addr == `WDG_REG_ADDR);
    wrHit  = busReq.wr && hit;
    run    = (q.pwr != PWR_STOP);
    tick   = 1'b0;
    step   = 1'b0;
    fire   = 1'b0;
    actNew = q.active;

    // Straps caught once after reset release
    if (!q.optValid) begin
      d.optHw    = optHwAct;
      d.optExt   = optExtStop;
      d.optValid = 1'b1;
      d.active   = optHwAct;
    end

    if (q.rstHold) begin
      d.rstCnt = q.rstCnt + 11'h001;
      if (q.rstCnt == `WDG_STAB_LAST) begin
        d.rstHold = 1'b0;
        d.rstCnt  = 11'h000;
      end
    end else if (q.optValid) begin
      // Divide by twelve, then by 256
      if (run) begin
        tick  = (q.div == `WDG_DIV_LAST);
        d.div = tick ? 4'h0 : q.div + 4'h1;
      end
      if (tick) begin
        d.pre = q.pre + 8'h01;
        step  = (q.pre == `WDG_PRE_LAST);
      end
      if (step) begin
        d.cnt = q.cnt - 7'h01;
        // SR falls on leaving 40h: N+1 steps from count N
        fire  = q.active && (q.cnt == `WDG_CNT_SR_EDGE);
      end
      if (wrHit) begin
        // Reload restarts the step: a full step always follows a write
        d.div      = 4'h0;
        d.pre      = 8'h00;
        d.cnt[5:0] = rev6(busReq.wdata[`WDG_CNT_HI:`WDG_CNT_LO]);
        d.cnt[6]   = busReq.wdata[`WDG_BIT_SR];
        actNew     = q.active | q.optHw
                     | busReq.wdata[`WDG_BIT_ACT];
        d.active   = actNew;
        fire       = actNew && !busReq.wdata[`WDG_BIT_SR];
      end
      if (pwrCtl.stopReq && q.pwr == PWR_RUN) begin
        if (!q.active) begin
          d.pwr = PWR_STOP;
        end else if (q.optExt && pwrCtl.nmiLevel) begin
          d.pwr = PWR_STOP;
        end else begin
          d.pwr = PWR_WAIT;
        end
      end
      if (pwrCtl.wakeReq && q.pwr != PWR_RUN) begin
        d.pwr = PWR_RUN;
      end
      if (fire) begin
        d.rstHold = 1'b1;
        d.rstCnt  = 11'h000;
        d.cnt     = `WDG_CNT_RESET;
        d.active  = q.optHw;
        d.pwr     = PWR_RUN;
        d.div     = 4'h0;
        d.pre     = 8'h00;
      end
    end

    // Read port: data only in the cycle after the strobe
    d.rdData = 8'h00;
    if (busReq.rd && hit) begin
      d.rdData = {rev6(q.cnt[5:0]), q.cnt[6], q.active};
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      q          <= '0;
      q.pwr      <= PWR_RUN;
      q.cnt      <= `WDG_CNT_RESET;
    end else begin
      q <= d;
    end
  end

  // ==========================================================
  // Outputs
  assign regRdData    = q.rdData;
  assign chipResetReq = q.rstHold;
  assign wdgActive    = q.active;
  assign stopMode     = q.pwr[1];
  assign waitMode     = q.pwr[0];

  // ==========================================================
  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  sequence expiryStep;
    q.active && !q.rstHold && step && q.cnt == `WDG_CNT_SR_EDGE && !wrHit;
  endsequence

  sequence holdRelease;
    q.rstHold ##1 !q.rstHold;
  endsequence

  sequence stopInRun;
    pwrCtl.stopReq && q.pwr == PWR_RUN && !q.rstHold && q.optValid
      && !fire && !(pwrCtl.wakeReq);
  endsequence

  expiry_resets_a: assert property (
    expiryStep |=> q.rstHold && q.cnt == `WDG_CNT_RESET)
    else $error("expiry did not request reset");

  sr_write_reset_a: assert property (
    wrHit && !q.rstHold && q.optValid && q.active
      && !busReq.wdata[`WDG_BIT_SR] |=> q.rstHold)
    else $error("SR clear did not reset");

  inactive_no_reset_a: assert property (
    !q.active && !q.rstHold && !wrHit |=> !q.rstHold)
    else $error("inactive watchdog reset the chip");

  active_sticks_a: assert property (
    q.active && !q.rstHold && !fire |=> q.active)
    else $error("activation lost without reset");

  hold_length_a: assert property (
    $fell(q.rstHold) |-> $past(q.rstCnt) == `WDG_STAB_LAST)
    else $error("reset hold length wrong");

  reset_value_a: assert property (
    holdRelease |-> q.cnt == `WDG_CNT_RESET && q.active == q.optHw)
    else $error("reset value not restored");

  stop_disabled_a: assert property (
    stopInRun ##0 !q.active |=> stopMode && !waitMode)
    else $error("disabled STOP did not stop");

  stop_as_wait_a: assert property (
    stopInRun ##0 q.active && !(q.optExt && pwrCtl.nmiLevel)
      |=> waitMode && !stopMode)
    else $error("STOP not taken as WAIT");

  stop_freeze_a: assert property (
    stopMode && !wrHit && !pwrCtl.wakeReq |=> $stable(q.cnt))
    else $error("counter moved in stop mode");

  wake_resume_a: assert property (
    stopMode && pwrCtl.wakeReq && !wrHit |=> !stopMode && $stable(q.cnt))
    else $error("wake did not resume from held count");

  read_map_a: assert property (
    busReq.rd && hit |=> regRdData[7] == $past(q.cnt[0])
      && regRdData[2] == $past(q.cnt[5])
      && regRdData[0] == $past(q.active))
    else $error("register read mapping wrong");

  hw_reads_one_a: assert property (
    q.optValid && q.optHw && busReq.rd && hit && !q.rstHold
      |=> regRdData[`WDG_BIT_ACT])
    else $error("hardware activation bit read zero");

  div_twelve_a: assert property (
    run && !q.rstHold && q.optValid && q.div == `WDG_DIV_LAST
      |=> q.div == 4'h0)
    else $error("divider period wrong");

  step_only_on_tick_a: assert property (
    !q.rstHold && !wrHit && !(tick && q.pre == `WDG_PRE_LAST)
      |=> $stable(q.cnt) || q.rstHold)
    else $error("counter stepped off prescaler");

  // ==========================================================
  // Reload, activation, hold, counting, stop, wake and read checks
  sequence reloadHit;
    wrHit && !q.rstHold && q.optValid;
  endsequence

  reload_restarts_a: assert property (
    reloadHit |=> q.div == 4'h0 && q.pre == 8'h00)
    else $error("reload did not restart the step");

  sr_set_no_reset_a: assert property (
    reloadHit ##0 busReq.wdata[`WDG_BIT_SR] |=> !q.rstHold)
    else $error("reload with SR set reset the chip");

  hw_always_active_a: assert property (
    q.optValid && q.optHw |-> q.active)
    else $error("hardware activation not held");

  stop_halts_div_a: assert property (
    stopMode && !wrHit && !pwrCtl.wakeReq |=> $stable(q.div) && $stable(q.pre))
    else $error("timing chain ran in stop mode");

  hold_keeps_count_a: assert property (
    q.rstHold |=> q.cnt == `WDG_CNT_RESET)
    else $error("counter moved during reset hold");

  step_decrements_a: assert property (
    step && !wrHit && !fire
      |=> q.cnt == $past(q.cnt) - 7'h01)
    else $error("step did not decrement by one");

  wait_counts_a: assert property (
    waitMode && step && !wrHit && !fire
      |=> q.cnt == $past(q.cnt) - 7'h01)
    else $error("counter stalled in wait mode");

  wake_from_wait_a: assert property (
    waitMode && pwrCtl.wakeReq && !q.rstHold |=> !waitMode && !stopMode)
    else $error("wake did not leave wait mode");

  rd_one_cycle_a: assert property (
    !(busReq.rd && hit) |=> regRdData == 8'h00)
    else $error("read data stood past its cycle");

endmodule
`default_nettype wire

// ==== core/wdg_defines.svh ====
// Constants of the digital watchdog: register offset, field positions,
// reset value and timing counts.
// Assumes sys_clk is the internal clock at 25 MHz.
`ifndef WDG_DEFINES_SVH
`define WDG_DEFINES_SVH

// Register map
`define WDG_REG_ADDR     8'hd8
`define WDG_REG_RESET    8'hfe
`define WDG_BIT_ACT      0
`define WDG_BIT_SR       1
`define WDG_CNT_LO       2
`define WDG_CNT_HI       7

// Physical counter after reset, SR as bit 6
`define WDG_CNT_RESET    7'h7f
`define WDG_CNT_SR_EDGE  7'h40

// Timing chain
`define WDG_DIV          12
`define WDG_DIV_LAST     4'hb
`define WDG_PRESCALE     256
`define WDG_PRE_LAST     8'hff
`define WDG_STEP_CYCLES  (`WDG_DIV * `WDG_PRESCALE)
`define WDG_STAB_CYCLES  2048
`define WDG_STAB_LAST    11'h7ff

`endif

// ==== core/wdg_pkg.sv ====
// Types of the digital watchdog: bus carrier, power-control carrier,
// power state.
// Assumes nothing beyond a SystemVerilog compiler.
package wdg_pkg;

  // Register port request
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } regbus_req_s;

  // CPU power-control requests and NMI level
  typedef struct packed {
    logic stopReq;
    logic wakeReq;
    logic nmiLevel;
  } pwr_ctl_s;

  // Bit 1 = stop, bit 0 = wait
  typedef enum logic [1:0] {
    PWR_RUN  = 2'b00,
    PWR_WAIT = 2'b01,
    PWR_STOP = 2'b10
  } pwr_e;

endpackage

// ==== tb/digital_watchdog_timer_tb.sv ====
// Self-checking bench of the digital watchdog: register port, expiry,
// stabilisation hold and stop/wait arbitration under strap settings hw/ext 0/0, 1/0 and 1/1.
// Assumes core/wdg_pkg.sv and core/digital_watchdog_timer.sv compile first.
`timescale 1ns/1ns
`default_nettype none
module digital_watchdog_timer_tb;
  import wdg_pkg::*;

  // ==========================================================
  // Signals and instance
  logic        sys_clk;
  logic        rst_b;
  regbus_req_s busReq;
  pwr_ctl_s    pwrCtl;
  logic        optHwAct;
  logic        optExtStop;
  logic [7:0]  regRdData;
  logic        chipResetReq;
  logic        wdgActive;
  logic        stopMode;
  logic        waitMode;
  int          miscompares;
  int          nTests;
  logic [7:0]  v1;
  logic [7:0]  v2;
  int          n;

  digital_watchdog_timer i_dut (
    .sys_clk(sys_clk), .rst_b(rst_b), .busReq(busReq), .pwrCtl(pwrCtl),
    .optHwAct(optHwAct), .optExtStop(optExtStop), .regRdData(regRdData),
    .chipResetReq(chipResetReq), .wdgActive(wdgActive), .stopMode(stopMode),
    .waitMode(waitMode)
  );

  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  // ==========================================================
  // Compare, access and closing tasks
  task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
    nTests++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk1(input string what, input logic exp, input logic got);
    nTests++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic cycles(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask

  task automatic regWr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    busReq <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge sys_clk);
    busReq.wr <= 1'b0;
    #1;
  endtask

  task automatic regRd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    busReq <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge sys_clk);
    busReq.rd <= 1'b0;
    #1 d = regRdData;
  endtask

  task automatic rdChk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    regRd(a, d);
    chk8("register read", exp, d);
  endtask

  // Polls the register until it changes; span in clocks
  task automatic stepWait(input logic [7:0] old, output logic [7:0] v, output int k);
    k = 0;
    do begin
      regRd(8'hd8, v);
      k += 2;
    end while (v === old && k < 8000);
  endtask

  task automatic pwrPulse(input logic stop);
    @(posedge sys_clk);
    pwrCtl.stopReq <= stop;
    pwrCtl.wakeReq <= ~stop;
    @(posedge sys_clk);
    pwrCtl.stopReq <= 1'b0;
    pwrCtl.wakeReq <= 1'b0;
    #1;
  endtask

  task automatic holdLen(output int k);
    k = 0;
    while (chipResetReq === 1'b1 && k < 3000) begin
      cycles(1);
      k++;
    end
  endtask

  task automatic doReset(input logic hw, input logic ext);
    rst_b      <= 1'b0;
    optHwAct   <= hw;
    optExtStop <= ext;
    cycles(16);
    rst_b <= 1'b1;
    cycles(2);
  endtask

  task automatic results;
    $display("Comparisons %0d mismatches %0d", nTests, miscompares);
    if (miscompares == 0 && nTests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    #(40 * 100000);
    miscompares++;
    results();
  end

  // ==========================================================
  // Tests
  initial begin
    miscompares = 0;
    nTests      = 0;
    rst_b       = 1'b0;
    busReq      = '0;
    pwrCtl      = '0;
    optHwAct    = 1'b0;
    optExtStop  = 1'b0;
    doReset(1'b0, 1'b0);
    rdChk(8'hd8, 8'hfe);
    rdChk(8'h55, 8'h00);
    regWr(8'h55, 8'h00);
    rdChk(8'hd8, 8'hfe);
    chk1("active", 1'b0, wdgActive);
    // Count 41h unarmed: free timer, reversed bits, one step per 3072 clocks
    regWr(8'hd8, 8'h82);
    stepWait(8'h82, v1, n);
    chk8("first step", 8'h02, v1);
    stepWait(8'h02, v2, n);
    chk8("free wrap", 8'hfc, v2);
    chk1("step span", 1'b1, n >= 3070 && n <= 3074);
    chk1("no reset", 1'b0, chipResetReq);
    // Armed expiry and stabilisation hold
    regWr(8'hd8, 8'h83);
    chk1("armed", 1'b1, wdgActive);
    n = 0;
    while (chipResetReq !== 1'b1 && n < 7000) begin
      cycles(1);
      n++;
    end
    chk1("expiry span", 1'b1, n == 2 * 3072);
    holdLen(n);
    chk1("hold length", 1'b1, n == 2048);
    chk1("disarmed", 1'b0, wdgActive);
    rdChk(8'hd8, 8'hfe);
    // Sticky activation, SR cleared by write
    regWr(8'hd8, 8'hff);
    regWr(8'hd8, 8'hfe);
    rdChk(8'hd8, 8'hff);
    regWr(8'hd8, 8'hfd);
    chk1("sr reset", 1'b1, chipResetReq);
    holdLen(n);
    chk1("sr hold", 1'b1, n == 2048);
    // Unarmed stop freezes, wake resumes
    pwrPulse(1'b1);
    chk1("stop", 1'b1, stopMode);
    chk1("no wait", 1'b0, waitMode);
    regRd(8'hd8, v1);
    cycles(3200);
    regRd(8'hd8, v2);
    chk8("frozen", v1, v2);
    pwrPulse(1'b0);
    chk1("woken", 1'b0, stopMode);
    stepWait(v2, v1, n);
    chk1("resumed", 1'b1, n <= 3074);
    // Hardware activation without external control
    doReset(1'b1, 1'b0);
    chk1("hw active", 1'b1, wdgActive);
    rdChk(8'hd8, 8'hff);
    regWr(8'hd8, 8'hfe);
    rdChk(8'hd8, 8'hff);
    pwrPulse(1'b1);
    chk1("stop as wait", 1'b1, waitMode);
    chk1("no stop", 1'b0, stopMode);
    stepWait(8'hff, v1, n);
    chk8("wait step", 8'h7f, v1);
    pwrPulse(1'b0);
    // Refresh a count-0 load well inside one step: no reset may follow
    repeat (3) begin
      regWr(8'hd8, 8'h02);
      cycles(2000);
    end
    chk1("refreshed", 1'b0, chipResetReq);
    // Hardware activation with external control
    doReset(1'b1, 1'b1);
    pwrCtl.nmiLevel <= 1'b0;
    pwrPulse(1'b1);
    chk1("nmi low wait", 1'b1, waitMode);
    stepWait(8'hff, v1, n);
    chk8("wait counts", 8'h7f, v1);
    pwrPulse(1'b0);
    pwrCtl.nmiLevel <= 1'b1;
    pwrPulse(1'b1);
    chk1("nmi high stop", 1'b1, stopMode);
    regRd(8'hd8, v1);
    cycles(3200);
    regRd(8'hd8, v2);
    chk8("held count", v1, v2);
    pwrPulse(1'b0);
    stepWait(v2, v1, n);
    chk1("resume", 1'b1, n <= 3074);
    results();
  end

endmodule
`default_nettype wire
